// ==== inc/smp_pkg.sv ====
// Package: constants and types for the serial modem port
`default_nettype none
package smp_pkg;
  // Character format
  localparam int unsigned DATA_BITS = 7;
  localparam int unsigned CHAR_W    = 7;
  // Flow-control characters
  localparam logic [6:0] CHAR_XON  = 7'h11;
  localparam logic [6:0] CHAR_XOFF = 7'h13;
  localparam logic [6:0] CHAR_ENQ  = 7'h05;
  localparam logic [6:0] CHAR_ACK  = 7'h06;
  // Receive buffer limits
  localparam int unsigned RX_BUF_MAX   = 128;
  localparam int unsigned RX_XOFF_LVL  = 96;
  localparam int unsigned RX_XON_LVL   = 32;
  localparam int unsigned RX_ACK_SPACE = 100;
  // Timing
  localparam longint unsigned CLK_HZ       = 64'd20000000;
  localparam int unsigned     OVERSAMPLE   = 16;
  localparam int unsigned     DSR_WAIT_S   = 60;
  localparam longint unsigned DSR_WAIT_CYC = CLK_HZ * DSR_WAIT_S;
  localparam logic [2:0]      SPEED_FIXED  = 3'h2;
  // Speed codes
  typedef enum logic [3:0] {
    SMP_B300, SMP_B600, SMP_B1200, SMP_B1800, SMP_B2400, SMP_B4800, SMP_B9600, SMP_SELECT
  } smp_speed_type;
  // Parity modes
  typedef enum logic [1:0] {
    SMP_PAR_ZERO, SMP_PAR_ONE, SMP_PAR_ODD, SMP_PAR_EVEN
  } smp_parity_type;
  // Oversample divisors per speed (clk / (baud*16)), indexed by speed code
  function automatic logic [15:0] smp_divisor(input logic [2:0] code);
    logic [15:0] d;
    d = 16'h0001;
    case (code)
      3'h0:    d = 16'h1046;
      3'h1:    d = 16'h0823;
      3'h2:    d = 16'h0412;
      3'h3:    d = 16'h02B6;
      3'h4:    d = 16'h0209;
      3'h5:    d = 16'h0104;
      3'h6:    d = 16'h0082;
      default: d = 16'h0412;
    endcase
    return d;
  endfunction
endpackage
`default_nettype wire

// ==== rtl/smp_port.sv ====
// Module: serial modem port with modem-control handshakes
`default_nettype none
module smp_port
  import smp_pkg::*;
#(
  parameter longint unsigned DSR_WAIT = smp_pkg::DSR_WAIT_CYC
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // Configuration
  input  wire logic                    cfg_modem,
  input  wire logic                    cfg_half_duplex,
  input  wire logic                    cfg_enq_ack,
  input  wire logic                    cfg_xon_rx,
  input  wire logic                    cfg_xon_tx,
  input  wire smp_pkg::smp_speed_type  cfg_speed,
  input  wire smp_pkg::smp_speed_type  cfg_high_speed,
  input  wire smp_pkg::smp_speed_type  cfg_low_speed,
  input  wire smp_pkg::smp_parity_type cfg_parity,
  input  wire logic                    cfg_two_stop,
  input  wire logic                    diag_dtr_override_switch,
  input  wire logic                    dtr_on_cmd,
  input  wire logic                    dtr_off_cmd,
  // Status
  output logic                         xon_available,
  output logic                         dtr_shown,
  output logic [2:0]                   eff_high_speed,
  output logic [2:0]                   eff_low_speed,
  output logic [2:0]                   active_speed,
  // Transmit user side
  input  wire logic [6:0]              tx_data,
  input  wire logic                    tx_valid,
  output logic                         tx_ready,
  // Receive user side
  output logic [6:0]                   rx_data,
  output logic                         rx_valid,
  input  wire logic                    rx_ready,
  output logic                         rx_parity_err,
  // Modem pins
  output logic                         txd,
  input  wire logic                    rxd,
  output logic                         rts,
  input  wire logic                    cts,
  output logic                         dtr,
  input  wire logic                    dsr,
  input  wire logic                    dcd,
  input  wire logic                    ring,
  input  wire logic                    rate_sel
);
  import smp_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] s_rxd, s_cts, s_dsr, s_dcd, s_ring, s_rsel;
  logic       rxd_f, cts_f, dsr_f, dcd_f, ring_f, rsel_f;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_rxd  <= 3'h7;
      s_cts  <= 3'h0;
      s_dsr  <= 3'h0;
      s_dcd  <= 3'h0;
      s_ring <= 3'h0;
      s_rsel <= 3'h0;
      rxd_f  <= 1'b1;
      cts_f  <= 1'b0;
      dsr_f  <= 1'b0;
      dcd_f  <= 1'b0;
      ring_f <= 1'b0;
      rsel_f <= 1'b0;
    end else begin
      s_rxd  <= {s_rxd[1:0], rxd};
      s_cts  <= {s_cts[1:0], cts};
      s_dsr  <= {s_dsr[1:0], dsr};
      s_dcd  <= {s_dcd[1:0], dcd};
      s_ring <= {s_ring[1:0], ring};
      s_rsel <= {s_rsel[1:0], rate_sel};
      if (s_rxd[1] == s_rxd[2]) rxd_f <= s_rxd[2];
      if (s_cts[1] == s_cts[2]) cts_f <= s_cts[2];
      if (s_dsr[1] == s_dsr[2]) dsr_f <= s_dsr[2];
      if (s_dcd[1] == s_dcd[2]) dcd_f <= s_dcd[2];
      if (s_ring[1] == s_ring[2]) ring_f <= s_ring[2];
      if (s_rsel[1] == s_rsel[2]) rsel_f <= s_rsel[2];
    end
  end

  // ------------------------------------------------------------
  // Data terminal ready supervision
  // ------------------------------------------------------------
  logic        dtr_q, dsr_seen_q;
  logic [31:0] dsr_wait_q;
  logic        link_up;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dtr_q      <= 1'b0;
      dsr_seen_q <= 1'b0;
      dsr_wait_q <= 32'h0;
    end else begin
      if (dsr_f) dsr_seen_q <= 1'b1;
      if (dtr_q && !dsr_f && !dsr_seen_q) dsr_wait_q <= dsr_wait_q + 32'h1;
      if (dtr_q && !dsr_f && !dsr_seen_q && dsr_wait_q >= 32'(DSR_WAIT - 1)) begin
        dtr_q <= 1'b0;
      end else if (dtr_q && !dsr_f && dsr_seen_q) begin
        dtr_q <= 1'b0;
      end else if (diag_dtr_override_switch && dtr_off_cmd) begin
        dtr_q <= 1'b0;
      end else if (!dtr_q) begin
        if (!diag_dtr_override_switch) dtr_q <= 1'b1;
        else if (dtr_on_cmd || ring_f) dtr_q <= 1'b1;
      end
      if (!dtr_q) begin
        dsr_seen_q <= 1'b0;
        dsr_wait_q <= 32'h0;
      end
    end
  end
  assign dtr       = dtr_q;
  assign dtr_shown = dtr_q;
  assign link_up   = dtr_q && dsr_f;

  // ------------------------------------------------------------
  // Speed selection
  // ------------------------------------------------------------
  logic [2:0] hi_c, lo_c, spd_q;
  logic [15:0] div_q, osc_q;
  logic        tick;
  assign hi_c = cfg_high_speed[2:0];
  assign lo_c = cfg_low_speed[2:0];
  assign eff_high_speed = (hi_c < lo_c) ? lo_c : hi_c;
  assign eff_low_speed  = (lo_c > hi_c) ? hi_c : lo_c;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      spd_q <= SPEED_FIXED;
      div_q <= 16'h0412;
    end else begin
      if (cfg_speed != SMP_SELECT) spd_q <= cfg_speed[2:0];
      else if (!cfg_modem) spd_q <= SPEED_FIXED;
      else spd_q <= rsel_f ? eff_high_speed : eff_low_speed;
      div_q <= smp_divisor(spd_q);
    end
  end
  assign active_speed = spd_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) osc_q <= 16'h0;
    else if (osc_q >= div_q - 16'h1) osc_q <= 16'h0;
    else osc_q <= osc_q + 16'h1;
  end
  assign tick = (osc_q == 16'h0);

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  typedef enum logic [1:0] {R_IDLE, R_START, R_BITS, R_STOP} smp_rx_state_type;
  smp_rx_state_type rst_q;
  logic [3:0]  rph_q;
  logic [3:0]  rbit_q;
  logic [7:0]  rsh_q;
  logic        rx_done, rx_par_bad, rx_accept;
  logic        rx_prev_q;
  function automatic logic par_of(input logic [6:0] d, input smp_parity_type m);
    logic p;
    p = 1'b0;
    case (m)
      SMP_PAR_ZERO: p = 1'b0;
      SMP_PAR_ONE:  p = 1'b1;
      SMP_PAR_ODD:  p = ~(^d);
      SMP_PAR_EVEN: p = ^d;
      default:      p = 1'b0;
    endcase
    return p;
  endfunction
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_q     <= R_IDLE;
      rph_q     <= 4'h0;
      rbit_q    <= 4'h0;
      rsh_q     <= 8'h0;
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rxd_f;
      case (rst_q)
        R_IDLE: if (rx_prev_q && !rxd_f) begin
          rst_q <= R_START;
          rph_q <= 4'h0;
        end
        R_START: if (tick) begin
          rph_q <= rph_q + 4'h1;
          if (rph_q == 4'(OVERSAMPLE / 2 - 1)) begin
            rph_q  <= 4'h0;
            rbit_q <= 4'h0;
            rst_q  <= rxd_f ? R_IDLE : R_BITS;
          end
        end
        R_BITS: if (tick) begin
          rph_q <= rph_q + 4'h1;
          if (rph_q == 4'(OVERSAMPLE - 1)) begin
            rsh_q  <= {rxd_f, rsh_q[7:1]};
            rbit_q <= rbit_q + 4'h1;
            if (rbit_q == 4'(DATA_BITS)) rst_q <= R_STOP;
          end
        end
        R_STOP: if (tick) begin
          rph_q <= rph_q + 4'h1;
          if (rph_q == 4'(OVERSAMPLE - 1)) rst_q <= R_IDLE;
        end
        default: rst_q <= R_IDLE;
      endcase
    end
  end
  assign rx_done    = (rst_q == R_STOP) && tick && (rph_q == 4'(OVERSAMPLE - 1)) && rxd_f;
  assign rx_par_bad = (rsh_q[7] != par_of(rsh_q[6:0], cfg_parity));
  assign rx_accept  = rx_done && link_up && dcd_f;

  // ------------------------------------------------------------
  // Receive buffer (two entries) and flow control
  // ------------------------------------------------------------
  logic [6:0] rb_d0_q, rb_d1_q;
  logic       rb_p0_q, rb_p1_q;
  logic [1:0] rb_cnt_q;
  logic       rb_push, rb_pop, is_ctl;
  logic       tx_paused_q, rx_held_q, send_xoff_q, send_xon_q, send_ack_q, tx_ctl_take;
  logic [7:0] fill_q;
  logic       xon_ok;
  assign xon_ok        = !cfg_half_duplex;
  assign xon_available = xon_ok;
  assign is_ctl = (xon_ok && cfg_xon_tx &&
                   (rsh_q[6:0] == CHAR_XON || rsh_q[6:0] == CHAR_XOFF)) ||
                  (cfg_enq_ack && rsh_q[6:0] == CHAR_ENQ);
  assign rb_push = rx_accept && !is_ctl && rb_cnt_q != 2'h2 && fill_q < 8'(RX_BUF_MAX);
  assign rb_pop  = rx_valid && rx_ready;
  assign rx_valid      = rb_cnt_q != 2'h0;
  assign rx_data       = rb_d0_q;
  assign rx_parity_err = rb_p0_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rb_d0_q  <= 7'h0;
      rb_d1_q  <= 7'h0;
      rb_p0_q  <= 1'b0;
      rb_p1_q  <= 1'b0;
      rb_cnt_q <= 2'h0;
    end else begin
      if (rb_pop) begin
        rb_d0_q <= rb_d1_q;
        rb_p0_q <= rb_p1_q;
      end
      if (rb_push) begin
        if (rb_cnt_q == 2'h0 || (rb_cnt_q == 2'h1 && rb_pop)) begin
          rb_d0_q <= rsh_q[6:0];
          rb_p0_q <= rx_par_bad;
        end else begin
          rb_d1_q <= rsh_q[6:0];
          rb_p1_q <= rx_par_bad;
        end
      end
      rb_cnt_q <= rb_cnt_q + {1'b0, rb_push} - {1'b0, rb_pop};
    end
  end
  // Fill level since the last ENQ, cleared when an ENQ is accepted, counted up on each push and down on each pop, holding at zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) fill_q <= 8'h0;
    else if (rx_accept && cfg_enq_ack && rsh_q[6:0] == CHAR_ENQ) fill_q <= 8'h0;
    else if (rb_push && !rb_pop) fill_q <= fill_q + 8'h1;
    else if (rb_pop && !rb_push && fill_q != 8'h0) fill_q <= fill_q - 8'h1;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_paused_q <= 1'b0;
      rx_held_q   <= 1'b0;
      send_xoff_q <= 1'b0;
      send_xon_q  <= 1'b0;
      send_ack_q  <= 1'b0;
    end else begin
      if (!(xon_ok && cfg_xon_tx)) tx_paused_q <= 1'b0;
      else if (rx_accept && rsh_q[6:0] == CHAR_XOFF) tx_paused_q <= 1'b1;
      else if (rx_accept && rsh_q[6:0] == CHAR_XON) tx_paused_q <= 1'b0;
      if (xon_ok && cfg_xon_rx && !rx_held_q && fill_q >= 8'(RX_XOFF_LVL)) begin
        rx_held_q   <= 1'b1;
        send_xoff_q <= 1'b1;
      end else if (rx_held_q && fill_q <= 8'(RX_XON_LVL)) begin
        rx_held_q  <= 1'b0;
        send_xon_q <= 1'b1;
      end
      if (rx_accept && cfg_enq_ack && rsh_q[6:0] == CHAR_ENQ &&
          rb_cnt_q == 2'h0) send_ack_q <= 1'b1;
      if (tx_ctl_take) begin
        if (send_xoff_q) send_xoff_q <= 1'b0;
        else if (send_xon_q) send_xon_q <= 1'b0;
        else send_ack_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Request to send and transmitter
  // ------------------------------------------------------------
  typedef enum logic [1:0] {T_IDLE, T_SHIFT} smp_tx_state_type;
  smp_tx_state_type tst_q;
  logic        rts_q, ctl_pend, tx_go, tx_clear;
  logic [11:0] tsh_q;
  logic [3:0]  tbits_q, tph_q;
  logic [6:0]  ctl_char;
  assign ctl_pend = send_xoff_q || send_xon_q || send_ack_q;
  assign ctl_char = send_xoff_q ? CHAR_XOFF : (send_xon_q ? CHAR_XON : CHAR_ACK);
  assign tx_clear = link_up && (!cfg_half_duplex || (rts_q && cts_f));
  assign tx_go       = tst_q == T_IDLE && tx_clear;
  assign tx_ctl_take = tx_go && ctl_pend;
  assign tx_ready    = tx_go && !ctl_pend && !tx_paused_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rts_q <= 1'b0;
    else if (!link_up) rts_q <= 1'b0;
    else if (!cfg_half_duplex) rts_q <= 1'b1;
    else if (!rts_q) rts_q <= (tx_valid || ctl_pend) && !cts_f;
    else if (tst_q == T_IDLE && !ctl_pend && !tx_valid) rts_q <= 1'b0;
  end
  assign rts = rts_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tst_q   <= T_IDLE;
      tsh_q   <= 12'hFFF;
      tbits_q <= 4'h0;
      tph_q   <= 4'h0;
      txd     <= 1'b1;
    end else begin
      case (tst_q)
        T_IDLE: begin
          txd <= 1'b1;
          if (tx_ctl_take || (tx_ready && tx_valid)) begin
            tsh_q <= {3'h7, par_of(tx_ctl_take ? ctl_char : tx_data, cfg_parity),
                      tx_ctl_take ? ctl_char : tx_data, 1'b0};
            tbits_q <= cfg_two_stop ? 4'hB : 4'hA;
            tph_q   <= 4'h0;
            tst_q   <= T_SHIFT;
          end
        end
        T_SHIFT: begin
          txd <= tsh_q[0];
          if (tick) begin
            tph_q <= tph_q + 4'h1;
            if (tph_q == 4'(OVERSAMPLE - 1)) begin
              tsh_q   <= {1'b1, tsh_q[11:1]};
              tbits_q <= tbits_q - 4'h1;
              if (tbits_q == 4'h1) tst_q <= T_IDLE;
            end
          end
        end
        default: tst_q <= T_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_rts_no_cts;
    @(posedge clk) disable iff (!reset_n)
      (cfg_half_duplex && !rts_q && cts_f) |=> !rts_q;
  endproperty
  a_rts_no_cts: assert property (p_rts_no_cts) else $error("rts raised with cts on");
  property p_full_rts;
    @(posedge clk) disable iff (!reset_n)
      (!cfg_half_duplex && link_up) |=> (rts_q || !link_up || cfg_half_duplex);
  endproperty
  a_full_rts: assert property (p_full_rts) else $error("rts off in full duplex");
  property p_half_cts;
    @(posedge clk) disable iff (!reset_n) (cfg_half_duplex && tx_ready) |-> cts_f && rts_q;
  endproperty
  a_half_cts: assert property (p_half_cts) else $error("tx without cts");
  property p_rx_gate;
    @(posedge clk) disable iff (!reset_n) rb_push |-> dtr_q && dsr_f && dcd_f;
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("rx accepted without lines");
  property p_dsr_drop;
    @(posedge clk) disable iff (!reset_n) (dtr_q && dsr_seen_q && !dsr_f) |=> !dtr_q;
  endproperty
  a_dsr_drop: assert property (p_dsr_drop) else $error("dtr held after dsr drop");
  property p_dtr_default;
    @(posedge clk) disable iff (!reset_n)
      (!diag_dtr_override_switch && !dtr_q && !(dsr_seen_q && !dsr_f)) |=> dtr_q;
  endproperty
  a_dtr_default: assert property (p_dtr_default) else $error("dtr not forced on");
  property p_hw_sel;
    @(posedge clk) disable iff (!reset_n)
      (cfg_speed == SMP_SELECT && !cfg_modem) [*2] |-> spd_q == SPEED_FIXED;
  endproperty
  a_hw_sel: assert property (p_hw_sel) else $error("hardwired select not 1200");
  property p_order;
    @(posedge clk) disable iff (!reset_n) eff_low_speed <= eff_high_speed;
  endproperty
  a_order: assert property (p_order) else $error("low above high");
  property p_xoff_pause;
    @(posedge clk) disable iff (!reset_n) tx_paused_q |-> !tx_ready;
  endproperty
  a_xoff_pause: assert property (p_xoff_pause) else $error("tx while paused");
  c_tx: cover property (@(posedge clk) tx_valid && tx_ready);
  c_rx: cover property (@(posedge clk) rb_push);
  c_dtr_to: cover property (@(posedge clk) $fell(dtr_q) && !dsr_seen_q);
endmodule // smp_port
`default_nettype wire

// ==== verification/smp_modem_model.sv ====
// Modem model driving the far-side pins of the serial port
`default_nettype none
module smp_modem_model #(
  parameter int BIT_CYC = 2080
) (
  // Clock
  input  wire logic clk,
  // From the port
  input  wire logic rts,
  // To the port
  output logic      rxd,
  output logic      cts,
  output logic      dsr,
  output logic      dcd,
  output logic      ring,
  output logic      rate_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       line_q  = 1'h1;
  logic       dsr_on  = 1'h0;
  logic       dcd_on  = 1'h0;
  logic       ring_on = 1'h0;
  logic       rate_on = 1'h0;
  logic [2:0] cts_q   = 3'h0;
  // CTS answers RTS after a short turnaround
  always @(posedge clk) begin
    cts_q <= {cts_q[1:0], rts};
  end
  assign cts      = cts_q[2];
  assign rxd      = line_q;
  assign dsr      = dsr_on;
  assign dcd      = dcd_on;
  assign ring     = ring_on;
  assign rate_sel = rate_on;
  // Start, data LSB first, parity, stop; line back at mark
  task automatic send(input logic [6:0] ch, input logic par);
    logic [9:0] f;
    f = {1'h1, par, ch, 1'h0};
    for (int i = 0; i < 10; i++) begin
      line_q = f[i];
      repeat (BIT_CYC) @(posedge clk);
      #2;
    end
  endtask
endmodule // smp_modem_model
`default_nettype wire

// ==== verification/smp_port_tb.sv ====
// Self-checking testbench for the serial modem port
`default_nettype none
module smp_port_tb import smp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT  = 2080;
  localparam int WAIT = 200;
  logic clk = 1'h0, reset_n, cfg_modem, cfg_half_duplex, cfg_enq_ack, cfg_xon_rx, cfg_xon_tx;
  smp_speed_type  cfg_speed, cfg_high_speed, cfg_low_speed;
  smp_parity_type cfg_parity;
  logic cfg_two_stop, diag, on_cmd, off_cmd, tx_valid, tx_ready, rx_valid, rx_ready;
  logic xon_available, dtr_shown, rx_parity_err, txd, rxd, rts, cts, dtr, dsr, dcd, ring, rate_sel;
  logic [2:0] eff_high_speed, eff_low_speed, active_speed;
  logic [6:0] tx_data, rx_data;
  int fail_count = 0;
  int samples_checked = 0;
  always #25 clk = ~clk;
  smp_port #(.DSR_WAIT(WAIT)) dut (.clk(clk), .reset_n(reset_n), .cfg_modem(cfg_modem),
    .cfg_half_duplex(cfg_half_duplex), .cfg_enq_ack(cfg_enq_ack), .cfg_xon_rx(cfg_xon_rx),
    .cfg_xon_tx(cfg_xon_tx), .cfg_speed(cfg_speed), .cfg_high_speed(cfg_high_speed),
    .cfg_low_speed(cfg_low_speed), .cfg_parity(cfg_parity), .cfg_two_stop(cfg_two_stop),
    .diag_dtr_override_switch(diag), .dtr_on_cmd(on_cmd), .dtr_off_cmd(off_cmd),
    .xon_available(xon_available), .dtr_shown(dtr_shown), .eff_high_speed(eff_high_speed),
    .eff_low_speed(eff_low_speed), .active_speed(active_speed), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_parity_err(rx_parity_err), .txd(txd), .rxd(rxd), .rts(rts),
    .cts(cts), .dtr(dtr), .dsr(dsr), .dcd(dcd), .ring(ring), .rate_sel(rate_sel));
  smp_modem_model #(.BIT_CYC(BIT)) m (.clk(clk), .rts(rts), .rxd(rxd), .cts(cts), .dsr(dsr),
    .dcd(dcd), .ring(ring), .rate_sel(rate_sel));
  // ----
  // Shared tasks
  // ----
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'h1) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic do_reset(input logic up);
    reset_n = 1'h0;
    m.dsr_on = up;
    m.dcd_on = up;
    cyc(2);
    reset_n = 1'h1;
    cyc(10);
  endtask
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_dtr;
    int n;
    do_reset(1'h0);
    check(dtr === 1'h1, "dtr off after reset");
    check(dtr_shown === 1'h1, "dtr display off");
    for (n = 0; n < WAIT + 20 && dtr !== 1'h0; n++)
      cyc(1);
    check(dtr === 1'h0 && n > WAIT - 20, "dtr timeout wrong");
    check(dtr_shown === 1'h0, "dtr display stale");
    $display("dtr supervision test done");
  endtask
  task automatic t_manual;
    diag = 1'h1;
    do_reset(1'h1);
    check(dtr === 1'h0, "manual dtr rose alone");
    m.ring_on = 1'h1;
    cyc(10);
    m.ring_on = 1'h0;
    check(dtr === 1'h1, "ring ignored");
    cyc(10);
    off_cmd = 1'h1;
    cyc(1);
    off_cmd = 1'h0;
    cyc(10);
    check(dtr === 1'h0, "dtr off command ignored");
    on_cmd = 1'h1;
    cyc(1);
    on_cmd = 1'h0;
    cyc(10);
    check(dtr === 1'h1, "dtr on command ignored");
    diag = 1'h0;
    $display("manual dtr test done");
  endtask
  task automatic t_tx;
    logic [9:0] f;
    int n;
    do_reset(1'h1);
    check(rts === 1'h1, "rts off in full duplex");
    check(xon_available === 1'h1, "xon missing in full duplex");
    cfg_half_duplex = 1'h1;
    cyc(1);
    check(xon_available === 1'h0, "xon offered in half duplex");
    cfg_parity = SMP_PAR_ODD;
    cyc(20);
    check(rts === 1'h0, "rts held with nothing to send");
    tx_data = 7'h4B;
    tx_valid = 1'h1;
    for (n = 0; n < 100 && tx_ready !== 1'h1; n++)
      cyc(1);
    check(tx_ready === 1'h1, "transmitter never ready");
    check(rts === 1'h1 && cts === 1'h1, "sent without cts");
    cyc(1);
    tx_valid = 1'h0;
    for (n = 0; n < 50 && txd !== 1'h0; n++)
      cyc(1);
    cyc(BIT / 2);
    for (int i = 0; i < 10; i++) begin
      f[i] = txd;
      cyc(BIT);
    end
    check(f === {1'h1, 1'h1, 7'h4B, 1'h0}, "transmit frame");
    check(rts === 1'h0, "rts held after frame");
    cfg_half_duplex = 1'h0;
    cyc(10);
    $display("transmit test done");
  endtask
  task automatic t_rx;
    int n;
    cfg_parity = SMP_PAR_EVEN;
    m.send(7'h35, 1'h0);
    cyc(40);
    check(rx_valid === 1'h1 && rx_data === 7'h35, "char not received");
    check(rx_parity_err === 1'h0, "false parity error");
    rx_ready = 1'h1;
    cyc(1);
    rx_ready = 1'h0;
    check(rx_valid === 1'h0, "char not popped");
    m.send(7'h35, 1'h1);
    cyc(40);
    check(rx_parity_err === 1'h1, "parity error missed");
    rx_ready = 1'h1;
    cyc(1);
    rx_ready = 1'h0;
    m.dcd_on = 1'h0;
    cyc(10);
    m.send(7'h35, 1'h0);
    cyc(40);
    check(rx_valid === 1'h0, "char taken without carrier");
    m.dsr_on = 1'h0;
    for (n = 0; n < 20 && dtr !== 1'h0; n++)
      cyc(1);
    check(dtr === 1'h0, "dtr kept after dsr drop");
    $display("receive test done");
  endtask
  task automatic t_speed;
    cfg_speed = SMP_SELECT;
    cfg_high_speed = SMP_B2400;
    cfg_low_speed = SMP_B300;
    m.rate_on = 1'h1;
    cyc(10);
    check(active_speed === 3'h4, "high speed not used");
    m.rate_on = 1'h0;
    cyc(10);
    check(active_speed === 3'h0, "low speed not used");
    cfg_modem = 1'h0;
    cyc(10);
    check(active_speed === 3'h2, "hardwired select not 1200");
    cfg_low_speed = SMP_B9600;
    cfg_high_speed = SMP_B600;
    cyc(2);
    check((eff_low_speed <= eff_high_speed) === 1'h1, "low above high");
    $display("speed test done");
  endtask
  // ----
  // Main sequence and watchdog
  // ----
  initial begin
    reset_n = 1'h0;
    {cfg_half_duplex, cfg_enq_ack, cfg_xon_rx, cfg_xon_tx, cfg_two_stop} = 5'h00;
    {diag, on_cmd, off_cmd, tx_valid, rx_ready} = 5'h00;
    cfg_modem = 1'h1;
    cfg_speed = SMP_B9600;
    cfg_high_speed = SMP_B1200;
    cfg_low_speed = SMP_B300;
    cfg_parity = SMP_PAR_ONE;
    tx_data = 7'h00;
    t_dtr;
    t_manual;
    t_tx;
    t_rx;
    t_speed;
    finish_test;
  end
  initial begin
    cyc(150000);
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    finish_test;
  end
endmodule // smp_port_tb
`default_nettype wire
